// ### include/apparent_pkg.sv
// constants shared by the apparent energy datapath and its register file
// assumes a 10 MHz master clock and a 32-bit classic Wishbone register bus
package apparent_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int SAMPLE_PERIOD_NS = 400;
	localparam int STEP_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int PULSE_WIDTH_CYCLES = 64;

	localparam logic [7:0] OFS_LINE_CYCLE_MODE = 8'h00;
	localparam logic [7:0] OFS_COMPUTATION_MODE = 8'h04;
	localparam logic [7:0] OFS_WAVEFORM_MODE = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFS_ENERGY_DIVIDER = 8'h14;
	localparam logic [7:0] OFS_PULSE_NUMERATOR = 8'h18;
	localparam logic [7:0] OFS_PULSE_DENOMINATOR = 8'h1C;
	localparam logic [7:0] OFS_ZERO_CROSS_COUNT = 8'h20;
	localparam logic [7:0] OFS_APPARENT_GAIN_A = 8'h24;
	localparam logic [7:0] OFS_APPARENT_ENERGY_A = 8'h30;
	localparam logic [7:0] OFS_REACTIVE_ENERGY_A = 8'h3C;

	localparam int BIT_LINE_CYCLE_REACTIVE = 1;
	localparam int BIT_READ_CLEAR = 6;
	localparam int BIT_APPARENT_PULSE_SELECT = 7;
	localparam int BIT_APPARENT_HALF_FULL = 2;
	localparam int POS_PHASE_SUM_SELECT = 2;

	localparam logic [1:0] CFG_MEAN_AC_VOLTAGE = 2'b01;

	localparam logic [15:0] RST_ZERO_CROSS_COUNT = 16'hFFFF;
	localparam logic [15:0] RST_PULSE_RATIO = 16'h003F;
	localparam logic [31:0] CONVERTER_THRESHOLD = 32'h0040_0000;
endpackage

// ### hdl/phase_apparent_channel.sv
// one phase: rms product, averaging filter, gain, divider and energy accumulators
// assumes rms and reactive inputs come from logic on the same clock
`timescale 1ns/1ns
module phase_apparent_channel
	import apparent_pkg::*;
#(
	parameter int RMS_W     = 24,
	parameter int PW        = 24,
	parameter int ACC_W     = 41,
	parameter int LPF_SHIFT = 4
)
(
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	input  wire logic                 i_step,
	input  wire logic [RMS_W-1:0]     i_vrms,
	input  wire logic [RMS_W-1:0]     i_irms,
	input  wire logic [11:0]          i_gain,
	input  wire logic [7:0]           i_div,
	input  wire logic                 i_clear,
	input  wire logic signed [PW-1:0] i_reactive,
	input  wire logic                 i_line_mode,
	input  wire logic                 i_period_end,
	output logic [PW:0]               o_power,
	output logic [15:0]               o_apparent,
	output logic [15:0]               o_reactive
);
	logic [2*RMS_W-1:0]       product;
	logic [PW+LPF_SHIFT-1:0]  lpf_q;
	logic [PW+LPF_SHIFT-1:0]  lpf_d;
	logic [PW-1:0]            average;
	logic [12:0]              gain_factor;
	logic [PW+12:0]           scaled;
	logic [7:0]               div_cnt_q;
	logic [7:0]               div_cnt_d;
	logic [7:0]               div_last;
	logic                     add_now;
	logic [ACC_W-1:0]         acc_q;
	logic [ACC_W-1:0]         acc_d;
	logic signed [ACC_W-1:0]  rac_q;
	logic signed [ACC_W-1:0]  rac_d;
	logic [15:0]              snap_q;
	logic [15:0]              snap_d;

	// rms values are magnitudes, so the product never goes negative
	assign product = i_vrms * i_irms; // (R3)
	assign average = lpf_q[PW+LPF_SHIFT-1:LPF_SHIFT];
	// 4096 plus signed gain, always 2048..6143, fits unsigned 13 bits
	assign gain_factor = 13'(13'h1000 + {i_gain[11], i_gain}); // (R5)
	// no offset term here: offsets are trimmed in the rms values upstream
	assign scaled = (PW+13)'(average * gain_factor); // (R5) (R6)
	assign div_last = (i_div < 8'h02) ? 8'h00 : 8'(i_div - 8'h01); // (R8)
	assign add_now = i_step && (div_cnt_q >= div_last);

	always_comb
	begin
		lpf_d = lpf_q;
		div_cnt_d = div_cnt_q;
		if (i_step)
		begin
			// first-order average, same response as the active power filter
			lpf_d = lpf_q + (PW+LPF_SHIFT)'(product[2*RMS_W-1 -: PW])
				- (PW+LPF_SHIFT)'(average); // (R4)
			div_cnt_d = add_now ? 8'h00 : 8'(div_cnt_q + 8'h01); // (R8)
		end
		// clear and add in one cycle keep the new sample; wrap is natural
		acc_d = (i_clear ? '0 : acc_q) + (add_now ? ACC_W'(o_power) : '0); // (R7) (R9) (R11)
		rac_d = ((i_line_mode && i_period_end) ? '0 : rac_q)
			+ (i_step ? ACC_W'(i_reactive) : '0); // (R22)
		snap_d = (i_line_mode && i_period_end) ? rac_q[ACC_W-1 -: 16] : snap_q; // (R1)
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			lpf_q <= '0;
			div_cnt_q <= 8'h00;
			acc_q <= '0;
			rac_q <= '0;
			snap_q <= 16'h0000;
			o_power <= '0;
		end
		else
		begin
			lpf_q <= lpf_d;
			div_cnt_q <= div_cnt_d;
			acc_q <= acc_d;
			rac_q <= rac_d;
			snap_q <= snap_d;
			o_power <= scaled[PW+12:12];
		end
	end

	assign o_apparent = acc_q[ACC_W-1 -: 16]; // (R7)
	assign o_reactive = i_line_mode ? snap_q : rac_q[ACC_W-1 -: 16]; // (R1)
endmodule

// ### hdl/apparent_energy_accumulator.sv
// apparent energy datapath for three phases, shared pulse output and registers
// Summary of operation
// (R1) line-cycle reactive mode latches energy per period
// (R2) host keeps read-clear off in line-cycle modes
// (R3) apparent power is voltage rms times current rms
// (R4) product averaged by the power lowpass filter
// (R5) gain scales by one plus gain/4096
// (R6) no offset correction in this path
// (R7) 41-bit accumulator, register shows top 16
// (R8) divide by 8-bit divider, none for 0/1
// (R9) accumulator wraps to zero on overflow
// (R10) half-full interrupt on energy msb change
// (R11) read-clear zeroes energy register after read
// (R12) one accumulation step every four clocks
// (R13) selector code 01 feeds phase B mean AC voltage
// (R14) energy reflects all gains; host avoids current gain
// (R15) select bit routes apparent power to pulse
// (R16) sum select bits include phases A, B, C
// (R17) numerator/denominator scale output frequency
// (R18) one pulse per den/num converter pulses
// (R19) output pulse lasts 64 clocks
// (R20) irq stays low until status read
// (R21) selected apparent terms summed unsigned
// (R22) zero-crossing counter reloads each period
// assumes rms, reactive and zero-crossing inputs are synchronous to I_CLK
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
module apparent_energy_accumulator
	import apparent_pkg::*;
#(
	parameter int RMS_W     = 24,
	parameter int PW        = 24,
	parameter int LPF_SHIFT = 4
)
(
	input  wire logic                 I_CLK,
	input  wire logic                 I_RST,
	input  wire logic                 I_WB_CYC,
	input  wire logic                 I_WB_STB,
	input  wire logic                 I_WB_WE,
	input  wire logic [7:0]           I_WB_ADR,
	input  wire logic [31:0]          I_WB_DAT,
	input  wire logic [3:0]           I_WB_SEL,
	output logic [31:0]               O_WB_DAT,
	output logic                      O_WB_ACK,
	input  wire logic [RMS_W-1:0]     I_VRMS_A,
	input  wire logic [RMS_W-1:0]     I_VRMS_B,
	input  wire logic [RMS_W-1:0]     I_VRMS_C,
	input  wire logic [RMS_W-1:0]     I_IRMS_A,
	input  wire logic [RMS_W-1:0]     I_IRMS_B,
	input  wire logic [RMS_W-1:0]     I_IRMS_C,
	input  wire logic signed [PW-1:0] I_VAR_A,
	input  wire logic signed [PW-1:0] I_VAR_B,
	input  wire logic signed [PW-1:0] I_VAR_C,
	input  wire logic                 I_ZERO_CROSS,
	output logic                      O_SHARED_PULSE,
	output logic                      O_IRQ_N
);
	logic [7:0]        line_cycle_mode_reg_q;
	logic [7:0]        line_cycle_mode_reg_d;
	logic [7:0]        computation_mode_reg_q;
	logic [7:0]        computation_mode_reg_d;
	logic [7:0]        waveform_mode_reg_q;
	logic [7:0]        waveform_mode_reg_d;
	logic [7:0]        mask_q;
	logic [7:0]        mask_d;
	logic [7:0]        status_q;
	logic [7:0]        status_d;
	logic [7:0]        apparent_energy_divider_q;
	logic [7:0]        apparent_energy_divider_d;
	logic [15:0]       numerator_q;
	logic [15:0]       numerator_d;
	logic [15:0]       denominator_q;
	logic [15:0]       denominator_d;
	logic [15:0]       zero_cross_count_q;
	logic [15:0]       zero_cross_count_d;
	logic [11:0]       gain_q [3];
	logic [11:0]       gain_d [3];
	logic              ack_q;
	logic              ack_d;
	logic [31:0]       rdata_q;
	logic [31:0]       rdata_d;
	logic              irq_n_d;
	logic [1:0]        step_cnt_q;
	logic [1:0]        step_cnt_d;
	logic              step;
	logic [15:0]       zc_left_q;
	logic [15:0]       zc_left_d;
	logic              period_end;
	logic [2:0]        msb_q;
	logic [2:0]        msb_d;
	logic [31:0]       conv_q;
	logic [31:0]       conv_d;
	logic              conv_pulse;
	logic [16:0]       ratio_q;
	logic [16:0]       ratio_d;
	logic [6:0]        width_q;
	logic [6:0]        width_d;
	logic              pulse_d;

	logic              take;
	logic              rd_take;
	logic              wr_take;
	logic [7:0]        word_adr;
	logic [2:0]        clear;
	logic              read_clear;
	logic [RMS_W-1:0]  vrms_b;
	logic [RMS_W-1:0]  vrms [3];
	logic [RMS_W-1:0]  irms [3];
	logic signed [PW-1:0] reactive [3];
	logic [PW:0]       power [3];
	logic [15:0]       apparent [3];
	logic [15:0]       reactive_energy [3];
	logic [2:0]        phase_sum_select;
	logic [PW+2:0]     total_apparent;
	logic signed [PW+2:0] total_reactive;
	logic [PW+2:0]     conv_input;
	logic [15:0]       num_eff;
	logic [15:0]       den_eff;

	// registered ack, so a held request is taken once and ack drops after one cycle
	assign take = I_WB_CYC && I_WB_STB && !ack_q;
	assign rd_take = take && !I_WB_WE;
	assign wr_take = take && I_WB_WE;
	assign word_adr = {I_WB_ADR[7:2], 2'b00};
	assign read_clear = line_cycle_mode_reg_q[BIT_READ_CLEAR];
	assign phase_sum_select = computation_mode_reg_q[POS_PHASE_SUM_SELECT +: 3];

	// merges the enabled byte lanes of a write into a 16-bit register
	function automatic logic [15:0] lanes(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		lanes = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
	endfunction

	// phase B voltage from the mean of A and C in three-wire configuration
	assign vrms_b = (computation_mode_reg_q[1:0] == CFG_MEAN_AC_VOLTAGE)
		? RMS_W'(({1'b0, I_VRMS_A} + {1'b0, I_VRMS_C}) >> 1) : I_VRMS_B; // (R13)
	assign vrms[0] = I_VRMS_A;
	assign vrms[1] = vrms_b;
	assign vrms[2] = I_VRMS_C;
	assign irms[0] = I_IRMS_A;
	assign irms[1] = I_IRMS_B;
	assign irms[2] = I_IRMS_C;
	assign reactive[0] = I_VAR_A;
	assign reactive[1] = I_VAR_B;
	assign reactive[2] = I_VAR_C;

	genvar p;
	generate
		for (p = 0; p < 3; p++)
		begin : g_phase
			assign clear[p] = read_clear && rd_take
				&& (word_adr == 8'(OFS_APPARENT_ENERGY_A + 8'(4 * p))); // (R11)
			phase_apparent_channel #(
				.RMS_W     (RMS_W),
				.PW        (PW),
				.ACC_W     (41),
				.LPF_SHIFT (LPF_SHIFT)
			) u_channel (
				.i_clk        (I_CLK),
				.i_rst        (I_RST),
				.i_step       (step),
				.i_vrms       (vrms[p]),
				.i_irms       (irms[p]),
				.i_gain       (gain_q[p]),
				.i_div        (apparent_energy_divider_q),
				.i_clear      (clear[p]),
				.i_reactive   (reactive[p]),
				.i_line_mode  (line_cycle_mode_reg_q[BIT_LINE_CYCLE_REACTIVE]),
				.i_period_end (period_end),
				.o_power      (power[p]),
				.o_apparent   (apparent[p]),
				.o_reactive   (reactive_energy[p])
			); // (R14)
		end
	endgenerate

	// sample-rate enable and line-cycle period tracking
	assign step = (step_cnt_q == 2'(STEP_CYCLES - 1)); // (R12)
	assign period_end = line_cycle_mode_reg_q[BIT_LINE_CYCLE_REACTIVE] && I_ZERO_CROSS
		&& (zc_left_q <= 16'h0001); // (R1)

	always_comb
	begin
		step_cnt_d = step ? 2'h0 : 2'(step_cnt_q + 2'h1); // (R12)
		zc_left_d = zc_left_q;
		if (!line_cycle_mode_reg_q[BIT_LINE_CYCLE_REACTIVE] || period_end)
			zc_left_d = zero_cross_count_q; // (R22)
		else if (I_ZERO_CROSS)
			zc_left_d = 16'(zc_left_q - 16'h0001);
	end

	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			step_cnt_q <= 2'h0;
			zc_left_q <= RST_ZERO_CROSS_COUNT;
		end
		else
		begin
			step_cnt_q <= step_cnt_d;
			zc_left_q <= zc_left_d;
		end
	end

	// pulse path: unsigned apparent sum, or reactive sum floored at zero
	always_comb
	begin
		total_apparent = '0;
		total_reactive = '0;
		for (int i = 0; i < 3; i++)
		begin
			if (phase_sum_select[i])
			begin
				total_apparent = (PW+3)'(total_apparent + (PW+3)'(power[i])); // (R16) (R21)
				total_reactive = (PW+3)'(total_reactive + (PW+3)'(reactive[i])); // (R16)
			end
		end
		if (waveform_mode_reg_q[BIT_APPARENT_PULSE_SELECT])
			conv_input = total_apparent; // (R15)
		else
			conv_input = total_reactive[PW+2] ? '0 : total_reactive; // (R15)
		conv_d = step ? 32'(conv_q + 32'(conv_input)) : conv_q;
		conv_pulse = conv_d >= CONVERTER_THRESHOLD;
		if (conv_pulse)
			conv_d = 32'(conv_d - CONVERTER_THRESHOLD);
		// a zero in either divider register would stall the output, treat as one
		num_eff = (numerator_q == 16'h0000) ? 16'h0001 : numerator_q;
		den_eff = (denominator_q == 16'h0000) ? 16'h0001 : denominator_q;
		ratio_d = conv_pulse ? 17'(ratio_q + {1'b0, num_eff}) : ratio_q; // (R17)
		pulse_d = O_SHARED_PULSE;
		width_d = width_q;
		if (ratio_d >= {1'b0, den_eff})
		begin
			ratio_d = 17'(ratio_d - {1'b0, den_eff}); // (R18)
			pulse_d = 1'b1;
			width_d = 7'(PULSE_WIDTH_CYCLES - 1); // (R19)
		end
		else if (width_q != 7'h00)
			width_d = 7'(width_q - 7'h01);
		else
			pulse_d = 1'b0; // (R19)
	end

	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			conv_q <= 32'h0000_0000;
			ratio_q <= 17'h0_0000;
			width_q <= 7'h00;
			O_SHARED_PULSE <= 1'b0;
		end
		else
		begin
			conv_q <= conv_d;
			ratio_q <= ratio_d;
			width_q <= width_d;
			O_SHARED_PULSE <= pulse_d;
		end
	end

	// register file; energy msb changes set the sticky half-full flag
	always_comb
	begin
		line_cycle_mode_reg_d = line_cycle_mode_reg_q;
		computation_mode_reg_d = computation_mode_reg_q;
		waveform_mode_reg_d = waveform_mode_reg_q;
		mask_d = mask_q;
		apparent_energy_divider_d = apparent_energy_divider_q;
		numerator_d = numerator_q;
		denominator_d = denominator_q;
		zero_cross_count_d = zero_cross_count_q;
		gain_d = gain_q;
		msb_d = {apparent[2][15], apparent[1][15], apparent[0][15]};
		status_d = status_q;
		rdata_d = rdata_q;
		ack_d = take;
		if (rd_take && word_adr == OFS_IRQ_STATUS)
			status_d = 8'h00; // (R20)
		if (msb_d != msb_q)
			status_d[BIT_APPARENT_HALF_FULL] = 1'b1; // (R10)
		if (wr_take)
		begin
			unique case (word_adr)
				OFS_LINE_CYCLE_MODE:
					line_cycle_mode_reg_d = I_WB_SEL[0] ? I_WB_DAT[7:0] : line_cycle_mode_reg_q;
				OFS_COMPUTATION_MODE:
					computation_mode_reg_d = I_WB_SEL[0] ? I_WB_DAT[7:0] : computation_mode_reg_q;
				OFS_WAVEFORM_MODE:
					waveform_mode_reg_d = I_WB_SEL[0] ? I_WB_DAT[7:0] : waveform_mode_reg_q;
				OFS_IRQ_MASK:
					mask_d = I_WB_SEL[0] ? I_WB_DAT[7:0] : mask_q;
				OFS_ENERGY_DIVIDER:
					apparent_energy_divider_d = I_WB_SEL[0] ? I_WB_DAT[7:0]
						: apparent_energy_divider_q;
				OFS_PULSE_NUMERATOR:
					numerator_d = lanes(numerator_q, I_WB_DAT, I_WB_SEL);
				OFS_PULSE_DENOMINATOR:
					denominator_d = lanes(denominator_q, I_WB_DAT, I_WB_SEL);
				OFS_ZERO_CROSS_COUNT:
					zero_cross_count_d = lanes(zero_cross_count_q, I_WB_DAT, I_WB_SEL);
				default:
				begin
					for (int i = 0; i < 3; i++)
						if (word_adr == 8'(OFS_APPARENT_GAIN_A + 8'(4 * i)))
							gain_d[i] = 12'(lanes({4'h0, gain_q[i]}, I_WB_DAT, I_WB_SEL));
				end
			endcase
		end
		if (rd_take)
		begin
			unique case (word_adr)
				OFS_LINE_CYCLE_MODE:   rdata_d = {24'h00_0000, line_cycle_mode_reg_q};
				OFS_COMPUTATION_MODE:  rdata_d = {24'h00_0000, computation_mode_reg_q};
				OFS_WAVEFORM_MODE:     rdata_d = {24'h00_0000, waveform_mode_reg_q};
				OFS_IRQ_MASK:          rdata_d = {24'h00_0000, mask_q};
				OFS_IRQ_STATUS:        rdata_d = {24'h00_0000, status_q};
				OFS_ENERGY_DIVIDER:    rdata_d = {24'h00_0000, apparent_energy_divider_q};
				OFS_PULSE_NUMERATOR:   rdata_d = {16'h0000, numerator_q};
				OFS_PULSE_DENOMINATOR: rdata_d = {16'h0000, denominator_q};
				OFS_ZERO_CROSS_COUNT:  rdata_d = {16'h0000, zero_cross_count_q};
				default:
				begin
					// unmapped words still ack and read as zero
					rdata_d = 32'h0000_0000;
					for (int i = 0; i < 3; i++)
					begin
						if (word_adr == 8'(OFS_APPARENT_GAIN_A + 8'(4 * i)))
							rdata_d = {20'h0_0000, gain_q[i]};
						if (word_adr == 8'(OFS_APPARENT_ENERGY_A + 8'(4 * i)))
							rdata_d = {16'h0000, apparent[i]}; // (R7)
						if (word_adr == 8'(OFS_REACTIVE_ENERGY_A + 8'(4 * i)))
							rdata_d = {16'h0000, reactive_energy[i]}; // (R1)
					end
				end
			endcase
		end
		irq_n_d = !(|(status_d & mask_d)); // (R10) (R20)
	end

	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			line_cycle_mode_reg_q <= 8'h00;
			computation_mode_reg_q <= 8'h1C;
			waveform_mode_reg_q <= 8'h00;
			mask_q <= 8'h00;
			status_q <= 8'h00;
			apparent_energy_divider_q <= 8'h00;
			numerator_q <= RST_PULSE_RATIO;
			denominator_q <= RST_PULSE_RATIO;
			zero_cross_count_q <= RST_ZERO_CROSS_COUNT;
			gain_q <= '{default: 12'h000};
			msb_q <= 3'h0;
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			O_IRQ_N <= 1'b1;
		end
		else
		begin
			line_cycle_mode_reg_q <= line_cycle_mode_reg_d;
			computation_mode_reg_q <= computation_mode_reg_d;
			waveform_mode_reg_q <= waveform_mode_reg_d;
			mask_q <= mask_d;
			status_q <= status_d;
			apparent_energy_divider_q <= apparent_energy_divider_d;
			numerator_q <= numerator_d;
			denominator_q <= denominator_d;
			zero_cross_count_q <= zero_cross_count_d;
			gain_q <= gain_d;
			msb_q <= msb_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
			O_IRQ_N <= irq_n_d;
		end
	end

	assign O_WB_ACK = ack_q;
	assign O_WB_DAT = rdata_q;
endmodule

// ### verification/host_bus_model.sv
// host model: classic single-cycle register bus master
// assumes a registered one-cycle ack from the block
`timescale 1ns/1ns
module host_bus_model
	import apparent_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_ack,
	input  wire logic [31:0] i_dat,
	output logic             o_cyc,
	output logic             o_stb,
	output logic             o_we,
	output logic [7:0]       o_adr,
	output logic [31:0]      o_dat,
	output logic [3:0]       o_sel
);
	initial
	begin
		o_cyc = 1'b0;
		o_stb = 1'b0;
		o_we = 1'b0;
		o_adr = 8'h00;
		o_dat = 32'h0;
		o_sel = 4'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		// read-clear kept off while line-cycle mode runs
		if (w && a == OFS_LINE_CYCLE_MODE && d[BIT_LINE_CYCLE_REACTIVE])
			d[BIT_READ_CLEAR] = 1'b0;
		@(posedge i_clk);
		o_cyc <= 1'b1;
		o_stb <= 1'b1;
		o_we <= w;
		o_adr <= a;
		o_dat <= d;
		o_sel <= 4'h3;
		// no cycle limit: a missing ack is left to the bench watchdog
		do
		begin
			@(posedge i_clk);
		end
		while (i_ack !== 1'b1);
		q = i_dat;
		o_cyc <= 1'b0;
		o_stb <= 1'b0;
		o_we <= 1'b0;
		// released lines show junk, not the old request
		o_adr <= ~a;
		o_dat <= ~d;
	endtask
endmodule

// ### verification/apparent_energy_accumulator_monitor.sv
// checker: register bus answers, pulse width, irq hold
// assumes one clock domain and the asynchronous high reset
`timescale 1ns/1ns
module apparent_energy_accumulator_monitor
	import apparent_pkg::*;
(
	input  wire logic        I_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_WB_CYC,
	input  wire logic        I_WB_STB,
	input  wire logic        I_WB_WE,
	input  wire logic [7:0]  I_WB_ADR,
	input  wire logic [31:0] O_WB_DAT,
	input  wire logic        O_WB_ACK,
	input  wire logic        O_SHARED_PULSE,
	input  wire logic        O_IRQ_N
);
	logic       take;
	logic       rd;
	logic       st_rd;
	logic       msk_wr;
	logic [7:0] hi_d;
	logic [7:0] hi_q;
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);
	assign take = I_WB_CYC && I_WB_STB && !O_WB_ACK;
	assign rd = take && !I_WB_WE;
	assign st_rd = rd && I_WB_ADR[7:2] == OFS_IRQ_STATUS[7:2];
	assign msk_wr = take && I_WB_WE && I_WB_ADR[7:2] == OFS_IRQ_MASK[7:2];
	// saturates so a stuck pulse never wraps into a short one
	always_comb
	begin
		hi_d = 8'h00;
		if (O_SHARED_PULSE)
			hi_d = (hi_q == 8'hFF) ? hi_q : hi_q + 8'h01;
	end
	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			hi_q <= 8'h00;
		else
			hi_q <= hi_d;
	end
	sequence s_take;
		take;
	endsequence
	sequence s_ack;
		O_WB_ACK ##1 !O_WB_ACK;
	endsequence
	chk_wb_answer: assert property (s_take |=> s_ack)
		else $error("request not answered by one ack");
	chk_ack_cause: assert property (O_WB_ACK |-> $past(take))
		else $error("ack without request");
	chk_dat_holds: assert property (!$past(rd) |-> $stable(O_WB_DAT))
		else $error("read data moved without a read");
	chk_unmapped_zero: assert property (rd && I_WB_ADR >= 8'h48 |=> O_WB_DAT == 32'h0)
		else $error("unmapped read not zero");
	chk_upper_zero: assert property (O_WB_ACK |-> O_WB_DAT[31:16] == 16'h0000)
		else $error("upper read bits set");
	chk_div_width: assert property (rd && I_WB_ADR == OFS_ENERGY_DIVIDER |=> O_WB_DAT[31:8] == 24'h0)
		else $error("divider wider than 8 bits");
	chk_pulse_width: assert property ($fell(O_SHARED_PULSE) |-> hi_q >= PULSE_WIDTH_CYCLES)
		else $error("pulse too short");
	chk_irq_holds: assert property (!O_IRQ_N && !st_rd && !$past(st_rd) && !msk_wr
		&& !$past(msk_wr) |=> !O_IRQ_N)
		else $error("irq released without status read");
endmodule
bind apparent_energy_accumulator apparent_energy_accumulator_monitor apparent_energy_accumulator_monitor_i
(
	.I_CLK         (I_CLK),
	.I_RST         (I_RST),
	.I_WB_CYC      (I_WB_CYC),
	.I_WB_STB      (I_WB_STB),
	.I_WB_WE       (I_WB_WE),
	.I_WB_ADR      (I_WB_ADR),
	.O_WB_DAT      (O_WB_DAT),
	.O_WB_ACK      (O_WB_ACK),
	.O_SHARED_PULSE(O_SHARED_PULSE),
	.O_IRQ_N       (O_IRQ_N)
);

// ### verification/tb.sv
// bench: register resets, energy scaling, line cycle, shared pulse
// assumes host_bus_model makes every register access
`timescale 1ns/1ns
module tb
	import apparent_pkg::*;
();
	logic               clk;
	logic               rst;
	logic               cyc;
	logic               stb;
	logic               we;
	logic [7:0]         adr;
	logic [31:0]        wdat;
	logic [3:0]         sel;
	logic [31:0]        rdat;
	logic               ack;
	logic [23:0]        va, vb, vc, ia, ib, ic;
	logic signed [23:0] qa, qb, qc;
	logic               zc;
	logic               pulse;
	logic               irq_n;
	int                 errors;
	int                 checked;
	apparent_energy_accumulator apparent_energy_accumulator_i
	(
		.I_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
		.I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(sel), .O_WB_DAT(rdat), .O_WB_ACK(ack),
		.I_VRMS_A(va), .I_VRMS_B(vb), .I_VRMS_C(vc), .I_IRMS_A(ia), .I_IRMS_B(ib),
		.I_IRMS_C(ic), .I_VAR_A(qa), .I_VAR_B(qb), .I_VAR_C(qc), .I_ZERO_CROSS(zc),
		.O_SHARED_PULSE(pulse), .O_IRQ_N(irq_n)
	);
	host_bus_model host_bus_model_i
	(
		.i_clk(clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc), .o_stb(stb),
		.o_we(we), .o_adr(adr), .o_dat(wdat), .o_sel(sel)
	);
	task automatic print_verdict;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] got);
		checked++;
		if ((got >= lo && got <= hi) !== 1'b1)
		begin
			errors++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		host_bus_model_i.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		host_bus_model_i.xfer(1'b0, a, 32'h0, q);
	endtask
	task automatic set_rms(input logic [23:0] v, input logic [23:0] b, input logic [23:0] i);
		va <= v;
		vb <= b;
		vc <= v;
		{ia, ib, ic} <= {i, i, i};
	endtask
	task automatic t_reset_values;
		logic [31:0] q;
		rd(OFS_COMPUTATION_MODE, q);
		chk("comp_mode", 32'h1C, q);
		rd(OFS_PULSE_DENOMINATOR, q);
		chk("pulse_den", {16'h0, RST_PULSE_RATIO}, q);
		rd(OFS_ZERO_CROSS_COUNT, q);
		chk("zc_count", {16'h0, RST_ZERO_CROSS_COUNT}, q);
		wr(8'hF0, 32'hFFFF);
		rd(8'hF0, q);
		chk("unmapped", 32'h0, q);
		wr(OFS_ENERGY_DIVIDER, 32'h1FF);
		rd(OFS_ENERGY_DIVIDER, q);
		chk("divider", 32'hFF, q);
	endtask
	task automatic t_gain_ratio;
		logic [31:0] a, b, c;
		wr(OFS_ENERGY_DIVIDER, 32'h0);
		wr(OFS_APPARENT_GAIN_A, 32'h800);
		wr(OFS_APPARENT_GAIN_A + 8'h08, 32'h7FF);
		set_rms(24'hFFFFFF, 24'hFFFFFF, 24'hFFFFFF);
		repeat (4000) @(posedge clk);
		rd(OFS_APPARENT_ENERGY_A, a);
		rd(OFS_APPARENT_ENERGY_A + 8'h04, b);
		rd(OFS_APPARENT_ENERGY_A + 8'h08, c);
		chk_rng("energy_a", 200, 260, a);
		chk_rng("energy_b", 2 * a - 4, 2 * a + 4, b);
		chk_rng("energy_c", 3 * a - 6, 3 * a + 6, c);
	endtask
	task automatic t_divider;
		logic [31:0] q;
		logic [7:0]  dv [4] = '{8'h00, 8'h01, 8'h04, 8'hFF};
		int          e;
		wr(OFS_APPARENT_GAIN_A, 32'h0);
		wr(OFS_APPARENT_GAIN_A + 8'h08, 32'h0);
		wr(OFS_LINE_CYCLE_MODE, 32'h40);
		foreach (dv[k])
		begin
			wr(OFS_ENERGY_DIVIDER, {24'h0, dv[k]});
			rd(OFS_APPARENT_ENERGY_A + 8'h04, q);
			repeat (4000) @(posedge clk);
			rd(OFS_APPARENT_ENERGY_A + 8'h04, q);
			e = 500 / ((dv[k] > 1) ? dv[k] : 1);
			chk_rng("energy_div", (e > 3) ? e - 3 : 0, e + 3, q);
		end
	endtask
	task automatic zero_cross;
		zc <= 1'b1;
		@(posedge clk);
		zc <= 1'b0;
	endtask
	task automatic t_line_cycle;
		logic [31:0] r1, r2, r3;
		wr(OFS_COMPUTATION_MODE, 32'h0);
		wr(OFS_ENERGY_DIVIDER, 32'h0);
		wr(OFS_ZERO_CROSS_COUNT, 32'h2);
		wr(OFS_LINE_CYCLE_MODE, 32'h2);
		qa <= 24'h7FFFFF;
		for (int k = 1; k <= 4; k++)
		begin
			zero_cross;
			repeat (800) @(posedge clk);
			if (k == 2)
				rd(OFS_REACTIVE_ENERGY_A, r1);
			if (k == 3)
				rd(OFS_REACTIVE_ENERGY_A, r2);
		end
		rd(OFS_REACTIVE_ENERGY_A, r3);
		chk("reactive_hold", r1, r2);
		chk_rng("reactive_period", 98, 103, r3);
		wr(OFS_LINE_CYCLE_MODE, 32'h0);
		qa <= 24'h0;
	endtask
	task automatic t_pulse(input logic [7:0] m, input logic ap, input logic [15:0] num,
		input int exp);
		int   edges;
		int   highs;
		logic p;
		wr(OFS_COMPUTATION_MODE, {24'h0, m});
		wr(OFS_WAVEFORM_MODE, {24'h0, ap, 7'h0});
		wr(OFS_PULSE_NUMERATOR, {16'h0, num});
		repeat (800) @(posedge clk);
		edges = 0;
		highs = 0;
		p = 1'b0;
		for (int n = 0; n < 200 && pulse === 1'b1; n++)
			@(posedge clk);
		for (int n = 0; n < 6400 || (pulse === 1'b1 && n < 6600); n++)
		begin
			@(posedge clk);
			highs += (pulse === 1'b1);
			edges += (pulse === 1'b1 && p !== 1'b1);
			p = pulse;
		end
		chk_rng("pulse_count", (exp > 2) ? exp - 2 : 0, exp + 2, edges);
		chk("pulse_width", edges * PULSE_WIDTH_CYCLES, highs);
	endtask
	// energy msb needs far more cycles than the run allows; only the quiet state is seen
	task automatic t_irq;
		logic [31:0] q;
		wr(OFS_IRQ_MASK, 32'h4);
		rd(OFS_IRQ_MASK, q);
		chk("irq_mask", 32'h4, q);
		rd(OFS_IRQ_STATUS, q);
		chk("irq_status", 32'h0, q);
		chk("irq_n", 32'h1, {31'h0, irq_n});
	endtask
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		repeat (95000) @(posedge clk);
		errors++;
		print_verdict;
	end
	initial
	begin
		rst = 1'b1;
		{va, vb, vc, ia, ib, ic, qa, qb, qc, zc} = '0;
		errors = 0;
		checked = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset_values;
		t_gain_ratio;
		t_divider;
		t_line_cycle;
		set_rms(24'h400000, 24'h0, 24'h400000);
		wr(OFS_PULSE_DENOMINATOR, 32'h10);
		repeat (1200) @(posedge clk);
		t_pulse(8'h04, 1'b1, 16'h1, 25);
		t_pulse(8'h14, 1'b1, 16'h1, 50);
		t_pulse(8'h08, 1'b1, 16'h1, 0);
		t_pulse(8'h09, 1'b1, 16'h1, 25);
		t_pulse(8'h04, 1'b1, 16'h2, 50);
		t_pulse(8'h14, 1'b0, 16'h1, 0);
		t_irq;
		print_verdict;
	end
endmodule
